// >>> logic/tpl_defines.vh
// constants for the transceiver pin and power logic
// assumes a 25 MHz system clock
`ifndef TPL_DEFINES_VH
`define TPL_DEFINES_VH
// register offsets
`define TPL_OFS_STATUS 8'h6e
`define TPL_OFS_GATE 8'h71
`define TPL_OFS_CFG_A 8'h89
`define TPL_OFS_CFG_B 8'h8a
`define TPL_OFS_CFG_C 8'h8b
`define TPL_OFS_FLT_EN_A 8'hf8
`define TPL_OFS_FLT_EN_Q 8'hf9
`define TPL_OFS_GATE_EN_A 8'hfa
`define TPL_OFS_GATE_EN_Q 8'hfb
// status byte bits
`define TPL_ST_TXD_STATE 7
`define TPL_ST_SOFT_TXD 6
`define TPL_ST_IN1 5
`define TPL_ST_RATE_SELECT_INPUT 4
`define TPL_ST_SOFT_RS 3
`define TPL_ST_TXF 2
`define TPL_ST_RXL 1
`define TPL_ST_NRDY 0
// pin_config_a bits
`define TPL_CA_LOSS_SEL 0
`define TPL_CA_INV_LOSS 1
`define TPL_CA_INV_RS 2
`define TPL_CA_FORCE_RS 3
// quick trip vector positions
`define TPL_QT_TX_POWER_LOW_ALARM 1
`define TPL_QT_LOSS_LO 4
// alarm/quick-trip bits held off during the tx disable extension
`define TPL_SUP_ALM 8'ha0
`define TPL_SUP_QT 5'h12
// defaults
`define TPL_DEF_ADDR 8'ha2
`define TPL_DEF_CFG_A 8'h01
`define TPL_DEF_EN 8'h00
// timing
`define TPL_CLK_NS 40
`define TPL_RDY_NS 500000
`define TPL_EXT_NS 100000
`endif

// >>> logic/tpl_ext_timer.v
// one-shot down counter with busy level and done pulse
// start is a one-cycle pulse in the clk_sys_i domain
`timescale 1ns/10ps
module tpl_ext_timer
#(
    parameter W = 16,
    parameter [W-1:0] CYC = 16'd1
)
(
    // clock and reset
    input wire clk_sys_i,
    input wire reset_i,
    // control
    input wire start_i,
    input wire clear_i,
    output reg busy_o,
    output reg done_o
);
reg [W-1:0] cnt_ff;

always @(posedge clk_sys_i or posedge reset_i)
begin
    if (reset_i)
    begin
        cnt_ff <= {W{1'b0}};
        busy_o <= 1'b0;
        done_o <= 1'b0;
    end
    else if (clear_i)
    begin
        cnt_ff <= {W{1'b0}};
        busy_o <= 1'b0;
        done_o <= 1'b0;
    end
    else
    begin
        if (start_i)
            cnt_ff <= CYC;
        else if (cnt_ff != {W{1'b0}})
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        busy_o <= start_i | (cnt_ff > {{(W-1){1'b0}}, 1'b1});
        done_o <= ~start_i & (cnt_ff == {{(W-1){1'b0}}, 1'b1});
    end
end
endmodule

// >>> logic/tpl_latch_bank.v
// bank of sticky event bits, one per event line
// set wins over a clear in the same cycle
`timescale 1ns/10ps
module tpl_latch_bank
#(
    parameter W = 13
)
(
    // clock and reset
    input wire clk_sys_i,
    input wire reset_i,
    // events
    input wire [W-1:0] set_i,
    input wire clear_i,
    output reg [W-1:0] held_o
);
always @(posedge clk_sys_i or posedge reset_i)
begin
    if (reset_i)
        held_o <= {W{1'b0}};
    else
        held_o <= (held_o & ~{W{clear_i}}) | set_i;
end
endmodule

// >>> logic/tpl_pin_power.v
// digital pin logic and supply-state handling of a module controller
// supply comparators, converter alarms and quick trips arrive as
// levels synchronous to clk_sys_i; register port is the management side
//
// Summary of operation
// R01: below analog level, outputs off, volatile at defaults, shadow zero.
// R02: on reaching analog level recall nonvolatile into shadow, enable analog.
// R03: between levels keep recalled settings, analog off; resume at once.
// R04: below digital level volatile returns to defaults; recall again later.
// R05: not-ready reads 1 below analog level, clears within 500 us after.
// R06: stored management address used only after analog level and recall.
// R07: analog power-on sets supply-low alarm; cleared by conversion above limit.
// R08: fault output never latches before supply conversion above limit.
// R09: fault output asserted whenever supply below analog level.
// R10: both sigma outputs high impedance until initialization time elapsed.
// R11: loss select 1 passes external loss pin to loss output.
// R12: loss select 0 passes internal low-signal quick trip instead.
// R13: mux output readable in status; XOR with invert drives loss pin.
// R14: stored loss selection acts only after analog level and recall.
// R15: general input and rate-select input levels readable in status.
// R16: amplifier loss level is high-rate value when rate select high.
// R17: rate-select output follows input, forceable and invertible by software.
// R18: tx disable combines fault, pin, gate; soft disable acts like pin.
// R19: tx disable pulse extended; low alarms not latched; no gate from txp low.
// R20: gate built from same events under own enables, readable in gate register.
// R21: tx disable output high impedance while supply below analog level.
// R22: fault from input, alarms, quick trips; enables and latch configs apply.
// R23: latched fault stays until new tx disable cycle or power-on reset.
`timescale 1ns/10ps
`include "tpl_defines.vh"
module tpl_pin_power
#(
    parameter RDY_CYC = `TPL_RDY_NS / `TPL_CLK_NS,
    parameter EXT_CYC = `TPL_EXT_NS / `TPL_CLK_NS,
    parameter [7:0] PART_TAG = 8'h5a // arbitrary id value, not read
)
(
    // clock and reset
    input wire clk_sys_i,
    input wire reset_i,
    // supply comparators
    input wire above_analog_i,
    input wire above_digital_i,
    // nonvolatile image presented for recall
    input wire [7:0] nv_cfg_a_i,
    input wire [7:0] nv_cfg_b_i,
    input wire [7:0] nv_cfg_c_i,
    input wire [7:0] nv_addr_i,
    input wire nv_addr_sel_i,
    input wire [7:0] loss_level_high_rate_i,
    input wire [7:0] loss_level_low_rate_i,
    // monitor results
    input wire [7:0] alarm_vec_i,
    input wire [4:0] qt_vec_i,
    input wire vcc_conv_valid_i,
    input wire vcc_above_limit_i,
    // pins in
    input wire rx_loss_input_pin_i,
    input wire general_input_one_i,
    input wire rate_select_input_i,
    input wire tx_disable_pin_i,
    input wire tx_fault_input_i,
    input wire sigma_one_bit_i,
    input wire sigma_two_bit_i,
    // register port
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // pins out
    output reg tx_fault_output_o,
    output reg tx_disable_output_o,
    output reg tx_disable_oe_n_o,
    output reg rx_loss_output_o,
    output reg rx_loss_oe_n_o,
    output reg rate_select_output_o,
    output reg rate_select_oe_n_o,
    output reg sigma_one_o,
    output reg sigma_one_oe_n_o,
    output reg sigma_two_o,
    output reg sigma_two_oe_n_o,
    output reg fast_turnoff_gate_o,
    output reg [7:0] amp_loss_level_o,
    output reg [7:0] dev_addr_o,
    output reg analog_enable_o,
    output reg not_ready_flag_o,
    output reg supply_low_alarm_o
);
localparam EW = 13;

// shadow (nonvolatile image) and volatile state
reg recalled_ff;
reg poa_q_ff;
reg [7:0] cfg_a_ff;
reg [7:0] cfg_b_ff;
reg [7:0] cfg_c_ff;
reg [7:0] addr_sh_ff;
reg addr_sel_ff;
reg [7:0] flt_en_a_ff;
reg [4:0] flt_en_q_ff;
reg [7:0] gate_en_a_ff;
reg [4:0] gate_en_q_ff;
reg soft_txd_ff;
reg soft_rs_ff;
reg not_ready_ff;
reg supply_low_ff;
reg txd_in_q_ff;
reg rxl_ff;
reg gate_ff;
reg fault_ff;

wire pod_low;
wire poa_rise;
wire txd_in;
wire rdy_done;
wire ext_busy;
wire [EW-1:0] ev_vec;
wire [EW-1:0] live_flt;
wire [EW-1:0] latch_set;
wire [EW-1:0] held_flt;
wire [EW-1:0] sup_mask;
wire [EW-1:0] gate_mask;
wire wr_ok;
wire loss_mux;
wire rs_val;
wire loss_val;
wire fault_nxt;
wire gate_nxt;
wire txd_out;

assign pod_low = ~above_digital_i;
assign poa_rise = above_analog_i & ~poa_q_ff;
assign txd_in = tx_disable_pin_i | soft_txd_ff; // R18
assign ev_vec = {qt_vec_i, alarm_vec_i};
assign live_flt = ev_vec & {flt_en_q_ff, flt_en_a_ff}; // R22
// hold off low alarms while the disable pulse is extended;
// the delayed copy covers the drop cycle, before the timer shows busy
assign sup_mask = (txd_in | txd_in_q_ff | ext_busy) ?
    {`TPL_SUP_QT, `TPL_SUP_ALM} : {EW{1'b0}}; // R19
// no latching before supply shown good
assign latch_set = live_flt & {cfg_c_ff[4:0], cfg_b_ff} & ~sup_mask
    & {EW{~supply_low_ff & above_analog_i}}; // R08 R22
assign gate_mask = {gate_en_q_ff, gate_en_a_ff};
assign gate_nxt = |(ev_vec & gate_mask
    & ~({{4{1'b0}}, 1'b1, {8{1'b0}}}
    << (`TPL_QT_TX_POWER_LOW_ALARM))); // R19 R20
// supply-low alarm is nonmaskable toward the fault output
assign fault_nxt = ~above_analog_i | tx_fault_input_i | supply_low_ff
    | (|live_flt) | (|held_flt); // R08 R09 R22 R23
assign txd_out = txd_in | fault_ff | gate_ff; // R18
assign loss_mux = cfg_a_ff[`TPL_CA_LOSS_SEL] ?
    rx_loss_input_pin_i : qt_vec_i[`TPL_QT_LOSS_LO]; // R11 R12 R14
assign loss_val = rxl_ff ^ cfg_a_ff[`TPL_CA_INV_LOSS]; // R13
assign rs_val = (cfg_a_ff[`TPL_CA_FORCE_RS] ?
    soft_rs_ff : rate_select_input_i)
    ^ cfg_a_ff[`TPL_CA_INV_RS]; // R17
// writes to volatile state need the digital supply
assign wr_ok = reg_wr_i & above_digital_i;

// not-ready timer restarts on every return above the analog level
tpl_ext_timer
#(
    .W(24),
    // the flag sits two flops behind the timer, so count two less
    .CYC(RDY_CYC[23:0] - 24'd2)
)
u_rdy_timer
(
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .start_i(poa_rise),
    .clear_i(~above_analog_i),
    .busy_o(),
    .done_o(rdy_done)
);

// disable extension starts when the disable request drops
tpl_ext_timer
#(
    .W(24),
    .CYC(EXT_CYC[23:0])
)
u_ext_timer
(
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .start_i(txd_in_q_ff & ~txd_in),
    .clear_i(pod_low),
    .busy_o(ext_busy),
    .done_o()
);

// latched faults clear on a new disable cycle or power loss
tpl_latch_bank
#(
    .W(EW)
)
u_fault_latch
(
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .set_i(latch_set),
    .clear_i((txd_in & ~txd_in_q_ff) | ~above_analog_i), // R23
    .held_o(held_flt)
);

// shadow, configuration and volatile control
always @(posedge clk_sys_i or posedge reset_i)
begin
    if (reset_i)
    begin
        recalled_ff <= 1'b0;
        poa_q_ff <= 1'b0;
        cfg_a_ff <= 8'h00;
        cfg_b_ff <= 8'h00;
        cfg_c_ff <= 8'h00;
        addr_sh_ff <= 8'h00;
        addr_sel_ff <= 1'b0;
        flt_en_a_ff <= `TPL_DEF_EN;
        flt_en_q_ff <= 5'h00;
        gate_en_a_ff <= `TPL_DEF_EN;
        gate_en_q_ff <= 5'h00;
        soft_txd_ff <= 1'b0;
        soft_rs_ff <= 1'b0;
        not_ready_ff <= 1'b1;
        supply_low_ff <= 1'b1;
        txd_in_q_ff <= 1'b0;
    end
    else if (pod_low)
    begin
        // volatile back to defaults, shadow emptied
        recalled_ff <= 1'b0; // R04
        poa_q_ff <= 1'b0;
        cfg_a_ff <= 8'h00; // R01
        cfg_b_ff <= 8'h00;
        cfg_c_ff <= 8'h00;
        addr_sh_ff <= 8'h00;
        addr_sel_ff <= 1'b0;
        flt_en_a_ff <= `TPL_DEF_EN;
        flt_en_q_ff <= 5'h00;
        gate_en_a_ff <= `TPL_DEF_EN;
        gate_en_q_ff <= 5'h00;
        soft_txd_ff <= 1'b0;
        soft_rs_ff <= 1'b0;
        not_ready_ff <= 1'b1;
        supply_low_ff <= 1'b1;
        txd_in_q_ff <= 1'b0;
    end
    else
    begin
        poa_q_ff <= above_analog_i;
        txd_in_q_ff <= txd_in;
        // recall only once per digital power cycle
        if (poa_rise & ~recalled_ff)
        begin
            recalled_ff <= 1'b1; // R02
            cfg_a_ff <= nv_cfg_a_i;
            cfg_b_ff <= nv_cfg_b_i;
            cfg_c_ff <= nv_cfg_c_i;
            addr_sh_ff <= nv_addr_i;
            addr_sel_ff <= nv_addr_sel_i;
        end
        else if (wr_ok)
        begin
            if (reg_addr_i == `TPL_OFS_CFG_A)
                cfg_a_ff <= reg_wdata_i;
            if (reg_addr_i == `TPL_OFS_CFG_B)
                cfg_b_ff <= reg_wdata_i;
            if (reg_addr_i == `TPL_OFS_CFG_C)
                cfg_c_ff <= reg_wdata_i;
        end
        if (wr_ok)
        begin
            if (reg_addr_i == `TPL_OFS_STATUS)
            begin
                soft_txd_ff <= reg_wdata_i[`TPL_ST_SOFT_TXD]; // R18
                soft_rs_ff <= reg_wdata_i[`TPL_ST_SOFT_RS]; // R17
            end
            if (reg_addr_i == `TPL_OFS_FLT_EN_A)
                flt_en_a_ff <= reg_wdata_i;
            if (reg_addr_i == `TPL_OFS_FLT_EN_Q)
                flt_en_q_ff <= reg_wdata_i[4:0];
            if (reg_addr_i == `TPL_OFS_GATE_EN_A)
                gate_en_a_ff <= reg_wdata_i;
            if (reg_addr_i == `TPL_OFS_GATE_EN_Q)
                gate_en_q_ff <= reg_wdata_i[4:0];
        end
        // not ready from the drop until the timer runs out
        if (~above_analog_i)
            not_ready_ff <= 1'b1; // R05
        else if (rdy_done)
            not_ready_ff <= 1'b0; // R05
        // the power-on condition wins over a clearing conversion
        if (~above_analog_i)
            supply_low_ff <= 1'b1; // R07
        else if (vcc_conv_valid_i & vcc_above_limit_i)
            supply_low_ff <= 1'b0; // R07
    end
end

// pin side, every output from a flop
always @(posedge clk_sys_i or posedge reset_i)
begin
    if (reset_i)
    begin
        rxl_ff <= 1'b0;
        gate_ff <= 1'b0;
        fault_ff <= 1'b1;
        tx_fault_output_o <= 1'b1;
        tx_disable_output_o <= 1'b0;
        tx_disable_oe_n_o <= 1'b1;
        rx_loss_output_o <= 1'b0;
        rx_loss_oe_n_o <= 1'b1;
        rate_select_output_o <= 1'b0;
        rate_select_oe_n_o <= 1'b1;
        sigma_one_o <= 1'b0;
        sigma_one_oe_n_o <= 1'b1;
        sigma_two_o <= 1'b0;
        sigma_two_oe_n_o <= 1'b1;
        fast_turnoff_gate_o <= 1'b0;
        amp_loss_level_o <= 8'h00;
        dev_addr_o <= `TPL_DEF_ADDR;
        analog_enable_o <= 1'b0;
        not_ready_flag_o <= 1'b1;
        supply_low_alarm_o <= 1'b1;
    end
    else
    begin
        rxl_ff <= loss_mux; // R13
        gate_ff <= gate_nxt & above_analog_i; // R20
        fault_ff <= fault_nxt; // R09
        tx_fault_output_o <= fault_nxt; // R09
        // analog side runs only above the analog level
        analog_enable_o <= above_analog_i & recalled_ff; // R02 R03
        // open-drain rx loss and rate select pins: pull low when the value is 0
        tx_disable_output_o <= txd_out; // R18
        tx_disable_oe_n_o <= ~above_analog_i; // R21
        rx_loss_output_o <= 1'b0;
        rx_loss_oe_n_o <= loss_val | ~above_analog_i
            | ~recalled_ff; // R01 R13 R14
        rate_select_output_o <= 1'b0;
        rate_select_oe_n_o <= rs_val | ~above_analog_i; // R17 R03
        // sigma outputs float until the part is ready
        sigma_one_o <= sigma_one_bit_i;
        sigma_two_o <= sigma_two_bit_i;
        sigma_one_oe_n_o <= not_ready_ff | ~above_analog_i; // R10
        sigma_two_oe_n_o <= not_ready_ff | ~above_analog_i; // R10
        fast_turnoff_gate_o <= gate_nxt & above_analog_i; // R20
        amp_loss_level_o <= rate_select_input_i ?
            loss_level_high_rate_i : loss_level_low_rate_i; // R16
        dev_addr_o <= (addr_sel_ff & recalled_ff & above_analog_i) ?
            addr_sh_ff : `TPL_DEF_ADDR; // R06
        not_ready_flag_o <= not_ready_ff;
        supply_low_alarm_o <= supply_low_ff;
    end
end

// register read port, data one cycle after the strobe
always @(posedge clk_sys_i or posedge reset_i)
begin
    if (reset_i)
        reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
        case (reg_addr_i)
            `TPL_OFS_STATUS:
                reg_rdata_o <= {txd_out, soft_txd_ff,
                    general_input_one_i, rate_select_input_i,
                    soft_rs_ff, fault_ff, rxl_ff,
                    not_ready_ff}; // R05 R13 R15
            `TPL_OFS_GATE:
                reg_rdata_o <= {7'h00, gate_ff}; // R20
            `TPL_OFS_CFG_A:
                reg_rdata_o <= cfg_a_ff;
            `TPL_OFS_CFG_B:
                reg_rdata_o <= cfg_b_ff;
            `TPL_OFS_CFG_C:
                reg_rdata_o <= cfg_c_ff;
            `TPL_OFS_FLT_EN_A:
                reg_rdata_o <= flt_en_a_ff;
            `TPL_OFS_FLT_EN_Q:
                reg_rdata_o <= {3'h0, flt_en_q_ff};
            `TPL_OFS_GATE_EN_A:
                reg_rdata_o <= gate_en_a_ff;
            `TPL_OFS_GATE_EN_Q:
                reg_rdata_o <= {3'h0, gate_en_q_ff};
            default:
                reg_rdata_o <= 8'h00;
        endcase
    end
end
endmodule

// >>> testbench/tpl_pin_power_asserts.sv
// port checker for tpl_pin_power, bound into every instance
// assumes one clock domain and reset_i active high
`timescale 1ns/10ps
module tpl_pin_power_asserts
#(
    parameter RDY_CYC = 12500
)
(
    // clock and reset
    input wire clk_sys_i,
    input wire reset_i,
    // inputs watched
    input wire above_analog_i,
    input wire above_digital_i,
    input wire rate_select_input_i,
    input wire [7:0] loss_level_high_rate_i,
    input wire [7:0] loss_level_low_rate_i,
    input wire vcc_conv_valid_i,
    input wire vcc_above_limit_i,
    // outputs watched
    input wire tx_fault_output_o,
    input wire tx_disable_oe_n_o,
    input wire rx_loss_oe_n_o,
    input wire rate_select_oe_n_o,
    input wire sigma_one_oe_n_o,
    input wire sigma_two_oe_n_o,
    input wire [7:0] amp_loss_level_o,
    input wire [7:0] dev_addr_o,
    input wire analog_enable_o,
    input wire not_ready_flag_o,
    input wire supply_low_alarm_o
);
default clocking @(posedge clk_sys_i);
endclocking
default disable iff (reset_i);
// saturating run length above the analog level
reg [15:0] up_cnt_ff;
always @(posedge clk_sys_i or posedge reset_i)
begin
    if (reset_i)
        up_cnt_ff <= 16'h0000;
    else if (!above_analog_i)
        up_cnt_ff <= 16'h0000;
    else if (up_cnt_ff != 16'hffff)
        up_cnt_ff <= up_cnt_ff + 16'h0001;
end
// flag and alarm outputs sit two flops behind the comparator
a_nrdy_below: assert property (!above_analog_i |=> ##1
    not_ready_flag_o) else $error("not ready flag low below analog level");
a_nrdy_clear: assert property ((up_cnt_ff > RDY_CYC) |->
    !not_ready_flag_o) else $error("not ready flag stuck high");
a_fault_below: assert property (!above_analog_i |=> tx_fault_output_o)
    else $error("fault output low below analog level");
a_txd_release: assert property (!above_analog_i |=> tx_disable_oe_n_o)
    else $error("tx disable driven below analog level");
a_pins_release: assert property (!above_analog_i |=>
    rx_loss_oe_n_o && rate_select_oe_n_o) else $error("pins pulled low");
a_sigma_release: assert property (!above_analog_i |=>
    sigma_one_oe_n_o && sigma_two_oe_n_o) else $error("sigma driven early");
a_alarm_por: assert property (!above_analog_i |=> ##1
    supply_low_alarm_o) else $error("supply low alarm not set");
a_alarm_clear: assert property (analog_enable_o && above_analog_i &&
    vcc_conv_valid_i && vcc_above_limit_i |=> ##1 !supply_low_alarm_o)
    else $error("supply low alarm not cleared");
a_addr_default: assert property (!above_digital_i |=>
    dev_addr_o == 8'ha2) else $error("address not default");
a_level_pick: assert property (analog_enable_o && above_analog_i |=>
    amp_loss_level_o == ($past(rate_select_input_i) ?
    $past(loss_level_high_rate_i) : $past(loss_level_low_rate_i)))
    else $error("wrong amplifier loss level");
endmodule
bind tpl_pin_power tpl_pin_power_asserts #(.RDY_CYC(RDY_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .above_analog_i(above_analog_i), .above_digital_i(above_digital_i),
    .rate_select_input_i(rate_select_input_i),
    .loss_level_high_rate_i(loss_level_high_rate_i),
    .loss_level_low_rate_i(loss_level_low_rate_i),
    .vcc_conv_valid_i(vcc_conv_valid_i),
    .vcc_above_limit_i(vcc_above_limit_i),
    .tx_fault_output_o(tx_fault_output_o),
    .tx_disable_oe_n_o(tx_disable_oe_n_o), .rx_loss_oe_n_o(rx_loss_oe_n_o),
    .rate_select_oe_n_o(rate_select_oe_n_o),
    .sigma_one_oe_n_o(sigma_one_oe_n_o), .sigma_two_oe_n_o(sigma_two_oe_n_o),
    .amp_loss_level_o(amp_loss_level_o), .dev_addr_o(dev_addr_o),
    .analog_enable_o(analog_enable_o), .not_ready_flag_o(not_ready_flag_o),
    .supply_low_alarm_o(supply_low_alarm_o));

// >>> testbench/tpl_far_side.sv
// far side line model: pull-ups, laser driver input, loss comparator
// assumes oe_n low means the device pulls or drives the line
`timescale 1ns/10ps
module tpl_far_side
(
    // from device
    input wire rx_loss_oe_n_i,
    input wire rate_select_oe_n_i,
    input wire tx_disable_oe_n_i,
    input wire tx_disable_i,
    // comparator request from bench
    input wire loss_set_i,
    // line levels
    output wire rx_loss_line_o,
    output wire rate_select_line_o,
    output wire tx_disable_line_o,
    output wire rx_loss_cmp_o
);
// released open-drain lines float up to the pull-up level
assign rx_loss_line_o = rx_loss_oe_n_i;
assign rate_select_line_o = rate_select_oe_n_i;
// driver input pulled to disabled, so a released line is safe
assign tx_disable_line_o = tx_disable_oe_n_i ? 1'b1 : tx_disable_i;
assign rx_loss_cmp_o = loss_set_i;
endmodule

// >>> testbench/tpl_pin_power_tb.sv
// self-checking bench for tpl_pin_power with the far side line model
// assumes short ready and extension counts for simulation
`timescale 1ns/10ps
`include "tpl_defines.vh"
module tpl_pin_power_tb;
reg clk_sys_i = 1'b0;
reg reset_i = 1'b1;
reg ana = 1'b0, dig = 1'b1, conv = 1'b0, cmp = 1'b0, in1 = 1'b0;
reg rate_select_input = 1'b0, txd = 1'b0, tx_fault_input = 1'b0, sg1 = 1'b0, sg2 = 1'b0;
reg lim = 1'b0, asel = 1'b1;
reg wr = 1'b0, rd = 1'b0, rd_d1 = 1'b0, rd_d2 = 1'b0, v, m;
reg [7:0] nva = 8'h01, lv_hi = 8'h3c, lv_lo = 8'h0f, alm = 8'h00;
reg [7:0] addr = 8'h00, wd = 8'h00, ca;
reg [4:0] qt = 5'h00;
reg [31:0] r;
reg [15:0] expq [$];
reg [15:0] e;
wire [7:0] rdat, alv, dadr;
wire flt, txo, txoe, lsoe, lso, rsoe, rso, gate, rdy, alo, aen;
wire s1, s1oe, s2, s2oe, loss_ln, rs_ln, txd_ln, loss_pin;
integer seed = 27;
integer err_total = 0;
integer checks = 0;
integer n;
always #20 clk_sys_i = ~clk_sys_i;
tpl_pin_power #(.RDY_CYC(20), .EXT_CYC(10)) dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .above_analog_i(ana),
    .above_digital_i(dig), .nv_cfg_a_i(nva), .nv_cfg_b_i(8'h00),
    .nv_cfg_c_i(8'h00), .nv_addr_i(8'h50), .nv_addr_sel_i(asel),
    .loss_level_high_rate_i(lv_hi), .loss_level_low_rate_i(lv_lo),
    .alarm_vec_i(alm), .qt_vec_i(qt), .vcc_conv_valid_i(conv),
    .vcc_above_limit_i(lim), .rx_loss_input_pin_i(loss_pin),
    .general_input_one_i(in1), .rate_select_input_i(rate_select_input),
    .tx_disable_pin_i(txd), .tx_fault_input_i(tx_fault_input), .sigma_one_bit_i(sg1),
    .sigma_two_bit_i(sg2), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .tx_fault_output_o(flt), .tx_disable_output_o(txo),
    .tx_disable_oe_n_o(txoe), .rx_loss_output_o(lso),
    .rx_loss_oe_n_o(lsoe), .rate_select_output_o(rso),
    .rate_select_oe_n_o(rsoe), .sigma_one_o(s1), .sigma_one_oe_n_o(s1oe),
    .sigma_two_o(s2), .sigma_two_oe_n_o(s2oe),
    .fast_turnoff_gate_o(gate), .amp_loss_level_o(alv),
    .dev_addr_o(dadr), .analog_enable_o(aen), .not_ready_flag_o(rdy),
    .supply_low_alarm_o(alo));
tpl_far_side u_far (
    .rx_loss_oe_n_i(lsoe), .rate_select_oe_n_i(rsoe),
    .tx_disable_oe_n_i(txoe), .tx_disable_i(txo), .loss_set_i(cmp),
    .rx_loss_line_o(loss_ln), .rate_select_line_o(rs_ln),
    .tx_disable_line_o(txd_ln), .rx_loss_cmp_o(loss_pin));
task chk(input [7:0] got, input [7:0] exp, input [7:0] msk);
begin
    checks = checks + 1;
    if ((got & msk) !== (exp & msk))
    begin
        err_total = err_total + 1;
        $display("mismatch at %0t got %h exp %h", $time, got & msk,
            exp & msk);
    end
end
endtask
task give_verdict;
begin
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
task tick(input integer k);
begin
    repeat (k) @(posedge clk_sys_i);
    #1;
end
endtask
task wr_reg(input [7:0] a, input [7:0] d);
begin
    addr = a;
    wd = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
end
endtask
// spaced reads so the compare two edges later never meets a new read
task rd_reg(input [7:0] a, input [7:0] x, input [7:0] msk);
begin
    expq.push_back({msk, x});
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(2);
end
endtask
always @(posedge clk_sys_i)
begin
    if (rd_d2)
    begin
        e = expq.pop_front();
        chk(rdat, e[7:0], e[15:8]);
    end
    rd_d2 <= rd_d1;
    rd_d1 <= rd;
end
always @(posedge clk_sys_i)
    {sg1, sg2} <= #1 $random(seed);
initial
begin
    repeat (20000) @(posedge clk_sys_i);
    err_total = err_total + 1;
    give_verdict;
end
initial
begin
    tick(20);
    reset_i = 1'b0;
    tick(2);
    rd_reg(`TPL_OFS_STATUS, 8'h05, 8'h05);
    chk({s1oe, s2oe, aen}, 3'h6, 8'h07);
    ana = 1'b1;
    n = 0;
    while (rdy !== 1'b0 && n < 100)
    begin
        tick(1);
        n = n + 1;
    end
    chk(n <= 21, 1'b1, 8'h01);
    if (n == 100)
        give_verdict;
    rd_reg(`TPL_OFS_STATUS, 8'h04, 8'h05);
    conv = 1'b1;
    tick(1);
    lim = 1'b1;
    tick(1);
    conv = 1'b0;
    chk(alo, 1'b1, 8'h01);
    tick(3);
    chk(alo, 1'b0, 8'h01);
    chk(flt, 1'b0, 8'h01);
    chk(dadr, 8'h50, 8'hff);
    chk({s1oe, s2oe, aen, lso, rso}, 5'h04, 8'h1f);
    for (n = 0; n < 8; n = n + 1)
    begin
        v = n[0];
        ca = {6'h00, n[2], ~n[1]};
        wr_reg(`TPL_OFS_CFG_A, ca);
        cmp = v;
        qt[4] = ~v;
        tick(2);
        m = ca[0] ? v : ~v;
        chk(loss_ln, m ^ ca[1], 8'h01);
        rd_reg(`TPL_OFS_STATUS, {6'h00, m, 1'b0}, 8'h02);
    end
    for (n = 0; n < 8; n = n + 1)
    begin
        r = $random(seed);
        {in1, rate_select_input} = r[1:0];
        lv_hi = r[15:8];
        lv_lo = r[23:16];
        wr_reg(`TPL_OFS_CFG_A, {4'h0, n[2], n[1], 2'b01});
        wr_reg(`TPL_OFS_STATUS, {4'h0, r[2], 3'h0});
        tick(2);
        chk(rs_ln, (n[2] ? r[2] : rate_select_input) ^ n[1], 8'h01);
        chk(alv, rate_select_input ? lv_hi : lv_lo, 8'hff);
        rd_reg(`TPL_OFS_STATUS, {2'b00, in1, rate_select_input, 4'h0}, 8'h30);
    end
    txd = 1'b1;
    tick(3);
    chk({txoe, txd_ln}, 2'b01, 8'h03);
    txd = 1'b0;
    tick(3);
    chk(txo, 1'b0, 8'h01);
    wr_reg(`TPL_OFS_STATUS, 8'h40);
    tick(2);
    chk(txo, 1'b1, 8'h01);
    rd_reg(`TPL_OFS_STATUS, 8'hc0, 8'hc0);
    wr_reg(`TPL_OFS_STATUS, 8'h00);
    tx_fault_input = 1'b1;
    tick(3);
    chk({flt, txo}, 2'b11, 8'h03);
    tx_fault_input = 1'b0;
    tick(15);
    wr_reg(`TPL_OFS_FLT_EN_A, 8'h01);
    wr_reg(`TPL_OFS_CFG_B, 8'h01);
    wr_reg(`TPL_OFS_GATE_EN_A, 8'h01);
    alm = 8'h01;
    tick(2);
    chk(gate, 1'b1, 8'h01);
    rd_reg(`TPL_OFS_GATE, 8'h01, 8'h01);
    alm = 8'h00;
    tick(3);
    chk(flt, 1'b1, 8'h01);
    txd = 1'b1;
    tick(1);
    txd = 1'b0;
    tick(15);
    chk(flt, 1'b0, 8'h01);
    wr_reg(`TPL_OFS_FLT_EN_Q, 8'h02);
    wr_reg(`TPL_OFS_CFG_C, 8'h02);
    wr_reg(`TPL_OFS_GATE_EN_Q, 8'h02);
    txd = 1'b1;
    tick(1);
    txd = 1'b0;
    qt = 5'h02;
    tick(2);
    chk(gate, 1'b0, 8'h01);
    qt = 5'h00;
    tick(15);
    chk(flt, 1'b0, 8'h01);
    qt = 5'h02;
    tick(1);
    qt = 5'h00;
    tick(3);
    chk(flt, 1'b1, 8'h01);
    rd_reg(8'h10, 8'h00, 8'hff);
    ana = 1'b0;
    tick(3);
    chk({flt, txoe}, 2'b11, 8'h03);
    chk({aen, s1oe}, 2'b01, 8'h03);
    rd_reg(`TPL_OFS_CFG_A, 8'h0d, 8'hff);
    ana = 1'b1;
    tick(2);
    rd_reg(`TPL_OFS_CFG_A, 8'h0d, 8'hff);
    ana = 1'b0;
    dig = 1'b0;
    nva = 8'h00;
    asel = 1'b0;
    tick(3);
    chk(dadr, 8'ha2, 8'hff);
    dig = 1'b1;
    tick(2);
    ana = 1'b1;
    tick(3);
    rd_reg(`TPL_OFS_CFG_A, 8'h00, 8'hff);
    chk(dadr, 8'ha2, 8'hff);
    cmp = 1'b1;
    qt = 5'h00;
    tick(2);
    chk(loss_ln, 1'b0, 8'h01);
    give_verdict;
end
endmodule
